//--- idc_input_ddr_capture.sv
// Input double-data-rate capture register, top level
// Notes on behaviour
// - Split mode: first on rise, second on fall
// - Aligned mode re-registers fall sample on rise
// - Aligned mode pairs appear split across cycles
// - Pipelined mode adds stage after rise sample
// - Pipelined mode costs one extra cycle latency
// - Low force input drives both outputs zero
// - High force input drives both outputs one
// - Force timing sync on rise, or immediate
// - Reset loads each output's configured initial value
// - Static alignment select, split edge default
// - Enable low freezes capture and outputs unless a force input is raised
`default_nettype none

module idc_input_ddr_capture #(
  parameter idc_pkg::idc_mode_t capture_mode = idc_pkg::IDC_MODE_DEFAULT,
  parameter idc_pkg::idc_force_t force_timing_select = idc_pkg::IDC_FORCE_DEFAULT,
  parameter logic first_out_initial = idc_pkg::IDC_INIT_DEFAULT,
  parameter logic second_out_initial = idc_pkg::IDC_INIT_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic data_in,
  input wire logic clk_en,
  input wire logic low_set_in,
  input wire logic high_force_in,
  output logic first_data_out,
  output logic second_data_out
);

  // Reset image of the rising-edge state
  localparam idc_pkg::idc_rise_t RISE_RST = '{
    head: first_out_initial,
    first_q: first_out_initial,
    second_q: second_out_initial
  };

  // Forced images of the rising-edge state
  localparam idc_pkg::idc_rise_t RISE_ALL_LOW = '{
    head: idc_pkg::IDC_FORCE_LOW_VAL,
    first_q: idc_pkg::IDC_FORCE_LOW_VAL,
    second_q: idc_pkg::IDC_FORCE_LOW_VAL
  };
  localparam idc_pkg::idc_rise_t RISE_ALL_HIGH = '{
    head: idc_pkg::IDC_FORCE_HIGH_VAL,
    first_q: idc_pkg::IDC_FORCE_HIGH_VAL,
    second_q: idc_pkg::IDC_FORCE_HIGH_VAL
  };

  idc_pkg::idc_rise_t st_ff;
  idc_pkg::idc_rise_t nxt_st;

  logic async_clr;
  logic async_set;
  logic sync_clr;
  logic sync_set;
  logic fall_q;

  // Force conditioning shared by both capture edges
  idc_force_ctl #(
    .force_timing_select(force_timing_select)
  ) u_force (
    .clk(clk),
    .rstn(rstn),
    .low_set_in(low_set_in),
    .high_force_in(high_force_in),
    .async_clr(async_clr),
    .async_set(async_set),
    .sync_clr(sync_clr),
    .sync_set(sync_set)
  );

  // Falling-edge sample of the data pin, reset to the second initial value
  idc_fall_cap #(
    .init_val(second_out_initial)
  ) u_fall (
    .clk(clk),
    .rstn(rstn),
    .data_in(data_in),
    .clk_en(clk_en),
    .async_clr(async_clr),
    .async_set(async_set),
    .sync_clr(sync_clr),
    .sync_set(sync_set),
    .fall_q(fall_q)
  );

  // Sync force is seen only in sync timing; async is handled by the flops
  logic frc_lo_now;
  logic frc_hi_now;

  assign frc_lo_now = (force_timing_select == idc_pkg::idc_force_sync) && low_set_in;
  assign frc_hi_now = (force_timing_select == idc_pkg::idc_force_sync) && high_force_in;

  // Rising-edge next state per alignment mode
  always_comb begin
    nxt_st = st_ff;
    if (frc_lo_now) begin
      // Low force wins if both were raised, which the outside must not do
      nxt_st = RISE_ALL_LOW;
    end else if (frc_hi_now) begin
      nxt_st = RISE_ALL_HIGH;
    end else if (clk_en) begin
      unique case (capture_mode)
        idc_pkg::idc_split_edge: begin
          // First output follows the pin at every rising edge
          nxt_st.first_q = data_in;
        end
        idc_pkg::idc_aligned_edge: begin
          // Fall sample moved onto the rising edge beside the new rise sample
          nxt_st.first_q = data_in;
          nxt_st.second_q = fall_q;
        end
        idc_pkg::idc_aligned_pipelined: begin
          // Rise sample waits one stage so it meets the following fall sample
          nxt_st.head = data_in;
          nxt_st.first_q = st_ff.head;
          nxt_st.second_q = fall_q;
        end
      endcase
    end
  end

  // Rising-edge register; async force overrides everything but reset
  always_ff @(posedge clk or negedge rstn or posedge async_clr or posedge async_set) begin
    if (!rstn) begin
      st_ff <= RISE_RST;
    end else if (async_clr) begin
      st_ff <= RISE_ALL_LOW;
    end else if (async_set) begin
      st_ff <= RISE_ALL_HIGH;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // First output always from the rising-edge register
  assign first_data_out = st_ff.first_q;

  // Second output: falling-edge flop in split mode, rising-edge flop otherwise
  generate
    if (capture_mode == idc_pkg::idc_split_edge) begin : g_q2_fall
      assign second_data_out = fall_q;
    end else begin : g_q2_rise
      assign second_data_out = st_ff.second_q;
    end
  endgenerate

endmodule

`default_nettype wire

//--- idc_pkg.sv
// Shared types and constants for the input double-data-rate capture block
`default_nettype none

package idc_pkg;

  // Capture alignment choices
  typedef enum {
    idc_split_edge,
    idc_aligned_edge,
    idc_aligned_pipelined
  } idc_mode_t;

  // Timing of the two force inputs
  typedef enum {
    idc_force_sync,
    idc_force_async
  } idc_force_t;

  // Default alignment and force timing
  localparam idc_mode_t IDC_MODE_DEFAULT = idc_split_edge;
  localparam idc_force_t IDC_FORCE_DEFAULT = idc_force_sync;

  // Default initial value of each output
  localparam logic IDC_INIT_DEFAULT = 1'h0;

  // Levels driven by the two force inputs
  localparam logic IDC_FORCE_LOW_VAL = 1'h0;
  localparam logic IDC_FORCE_HIGH_VAL = 1'h1;

  // Inactive level of a force term
  localparam logic IDC_FORCE_IDLE = 1'h0;

  // Rising-edge state of the top block
  typedef struct packed {
    logic head;
    logic first_q;
    logic second_q;
  } idc_rise_t;

  // Falling-edge sample state
  typedef struct packed {
    logic smp;
  } idc_fall_t;

  // Registered force levels handed to the falling-edge stage
  typedef struct packed {
    logic lo;
    logic hi;
  } idc_frc_t;

  localparam idc_frc_t IDC_FRC_RST = '{lo: 1'h0, hi: 1'h0};

endpackage

`default_nettype wire

//--- idc_force_ctl.sv
// Force input conditioning: async terms and rising-edge sampled levels
`default_nettype none

module idc_force_ctl #(
  parameter idc_pkg::idc_force_t force_timing_select = idc_pkg::IDC_FORCE_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic low_set_in,
  input wire logic high_force_in,
  output logic async_clr,
  output logic async_set,
  output logic sync_clr,
  output logic sync_set
);

  idc_pkg::idc_frc_t st_ff;
  idc_pkg::idc_frc_t nxt_st;

  // Async terms pass straight through only in async timing
  generate
    if (force_timing_select == idc_pkg::idc_force_async) begin : g_async
      assign async_clr = low_set_in;
      assign async_set = high_force_in;
    end else begin : g_sync
      assign async_clr = idc_pkg::IDC_FORCE_IDLE;
      assign async_set = idc_pkg::IDC_FORCE_IDLE;
    end
  endgenerate

  // Force levels as seen at the rising edge
  always_comb begin
    nxt_st = st_ff;
    nxt_st.lo = low_set_in;
    nxt_st.hi = high_force_in;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= idc_pkg::IDC_FRC_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // The falling-edge stage only sees sync force in sync timing
  assign sync_clr = (force_timing_select == idc_pkg::idc_force_sync) ? st_ff.lo
                                                                     : idc_pkg::IDC_FORCE_IDLE;
  assign sync_set = (force_timing_select == idc_pkg::idc_force_sync) ? st_ff.hi
                                                                     : idc_pkg::IDC_FORCE_IDLE;

endmodule

`default_nettype wire

//--- idc_fall_cap.sv
// Falling-edge sample register of the data pin
`default_nettype none

module idc_fall_cap #(
  parameter logic init_val = idc_pkg::IDC_INIT_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic data_in,
  input wire logic clk_en,
  input wire logic async_clr,
  input wire logic async_set,
  input wire logic sync_clr,
  input wire logic sync_set,
  output logic fall_q
);

  idc_pkg::idc_fall_t st_ff;
  idc_pkg::idc_fall_t nxt_st;

  // Sync force beats the enable; enable low holds the sample
  always_comb begin
    nxt_st = st_ff;
    if (sync_clr) begin
      nxt_st.smp = idc_pkg::IDC_FORCE_LOW_VAL;
    end else if (sync_set) begin
      nxt_st.smp = idc_pkg::IDC_FORCE_HIGH_VAL;
    end else if (clk_en) begin
      nxt_st.smp = data_in;
    end
  end

  // Sampled on the falling edge, async force acts at once
  always_ff @(negedge clk or negedge rstn or posedge async_clr or posedge async_set) begin
    if (!rstn) begin
      st_ff.smp <= init_val;
    end else if (async_clr) begin
      st_ff.smp <= idc_pkg::IDC_FORCE_LOW_VAL;
    end else if (async_set) begin
      st_ff.smp <= idc_pkg::IDC_FORCE_HIGH_VAL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fall_q = st_ff.smp;

endmodule

`default_nettype wire

//--- idc_props.sv
// Checker of capture timing, force and reset behaviour
`default_nettype none
module idc_props #(
  parameter idc_pkg::idc_mode_t capture_mode = idc_pkg::IDC_MODE_DEFAULT,
  parameter idc_pkg::idc_force_t force_timing_select = idc_pkg::IDC_FORCE_DEFAULT,
  parameter logic first_out_initial = idc_pkg::IDC_INIT_DEFAULT,
  parameter logic second_out_initial = idc_pkg::IDC_INIT_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic data_in,
  input wire logic clk_en,
  input wire logic low_set_in,
  input wire logic high_force_in,
  input wire logic first_data_out,
  input wire logic second_data_out
);
  localparam bit PIP = capture_mode == idc_pkg::idc_aligned_pipelined;
  localparam bit ASY = force_timing_select == idc_pkg::idc_force_async;
  logic fall_d;
  logic nof;
  logic cap;
  // Falling-edge level of the data pin
  always_ff @(negedge clk) fall_d <= data_in;
  // No force active, and capture enabled
  assign nof = !low_set_in && !high_force_in;
  assign cap = clk_en && nof;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_cap2; cap ##1 cap; endsequence
  property p_first; !PIP && cap ##1 nof |-> first_data_out == $past(data_in); endproperty
  a_first: assert property (p_first) else $error("first output missed rise sample");
  property p_sec; !PIP && capture_mode != idc_pkg::idc_split_edge ##0 s_cap2 ##1 nof
    |-> second_data_out == $past(fall_d); endproperty
  a_sec: assert property (p_sec) else $error("second output missed fall sample");
  property p_pip; PIP ##0 s_cap2 ##1 nof |-> first_data_out == $past(data_in, 2)
    && second_data_out == $past(fall_d); endproperty
  a_pip: assert property (p_pip) else $error("pipelined pair wrong");
  property p_lo; !ASY && low_set_in |=> !first_data_out && !second_data_out; endproperty
  a_lo: assert property (p_lo) else $error("sync low force failed");
  property p_hi; !ASY && high_force_in && !low_set_in |=> first_data_out && second_data_out;
  endproperty
  a_hi: assert property (p_hi) else $error("sync high force failed");
  property p_alo; ASY && low_set_in |-> !first_data_out && !second_data_out; endproperty
  a_alo: assert property (p_alo) else $error("async low force failed");
  property p_ahi; ASY && high_force_in && !low_set_in |-> first_data_out && second_data_out;
  endproperty
  a_ahi: assert property (p_ahi) else $error("async high force failed");
  property p_hold; !clk_en && nof ##1 nof |-> $stable(first_data_out)
    && $stable(second_data_out); endproperty
  a_hold: assert property (p_hold) else $error("outputs moved while disabled");
  property p_init; $rose(rstn) |-> first_data_out == first_out_initial
    && second_data_out == second_out_initial; endproperty
  a_init: assert property (p_init) else $error("initial values wrong");
endmodule
bind idc_input_ddr_capture idc_props #(.capture_mode(capture_mode),
  .force_timing_select(force_timing_select), .first_out_initial(first_out_initial),
  .second_out_initial(second_out_initial)) u_props (.clk(clk), .rstn(rstn), .data_in(data_in),
  .clk_en(clk_en), .low_set_in(low_set_in), .high_force_in(high_force_in),
  .first_data_out(first_data_out), .second_data_out(second_data_out));
`default_nettype wire

//--- idc_ddr_src.sv
// Source that presents one bit pair per clock on the DDR data pin
`default_nettype none
module idc_ddr_src (
  input wire logic clk,
  input wire logic [1:0] pair,
  output logic data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Rise bit after each fall, fall bit after each rise, clear of the sample points
  initial begin
    data_in = 1'h0;
    forever begin
      @(clk);
      #1;
      data_in = clk ? pair[0] : pair[1];
    end
  end
endmodule
`default_nettype wire

//--- idc_input_ddr_capture_test.sv
// Testbench of the DDR capture block in three configurations
`default_nettype none
module idc_input_ddr_capture_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rstn, clk_en, lo, hi;
  logic [1:0] pair;
  wire data_in;
  wire [1:0] q_sp, q_al, q_pl;
  int err_count, check_count;
  logic [1:0] rows [8] = '{2'h2, 2'h1, 2'h3, 2'h0, 2'h1, 2'h0, 2'h1, 2'h3};
  idc_ddr_src u_src (.clk(clk), .pair(pair), .data_in(data_in));
  idc_input_ddr_capture u_dut (.clk(clk), .rstn(rstn), .data_in(data_in), .clk_en(clk_en),
    .low_set_in(lo), .high_force_in(hi), .first_data_out(q_sp[1]), .second_data_out(q_sp[0]));
  idc_input_ddr_capture #(.capture_mode(idc_pkg::idc_aligned_edge),
    .force_timing_select(idc_pkg::idc_force_async), .first_out_initial(1'h1)) u_dut_al (
    .clk(clk), .rstn(rstn), .data_in(data_in), .clk_en(clk_en), .low_set_in(lo),
    .high_force_in(hi), .first_data_out(q_al[1]), .second_data_out(q_al[0]));
  idc_input_ddr_capture #(.capture_mode(idc_pkg::idc_aligned_pipelined),
    .second_out_initial(1'h1)) u_dut_pl (.clk(clk), .rstn(rstn), .data_in(data_in),
    .clk_en(clk_en), .low_set_in(lo), .high_force_in(hi), .first_data_out(q_pl[1]),
    .second_data_out(q_pl[0]));
  // Compare and count
  task automatic chk(input logic [1:0] s, input logic [1:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %b, wanted %b", $time, s, e);
    end
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // 250 MHz clock
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // Reset, row loop, then enable and force cases
  initial begin
    rstn = 1'h0;
    clk_en = 1'h0;
    lo = 1'h0;
    hi = 1'h0;
    pair = 2'h0;
    err_count = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    chk(q_sp, 2'h0);
    chk(q_al, 2'h2);
    chk(q_pl, 2'h1);
    @(negedge clk);
    rstn <= 1'h1;
    clk_en <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      pair <= rows[i];
      #1.5;
      if (i > 0) chk({1'h0, q_sp[0]}, {1'h0, rows[i-1][0]});
      if (i > 1) chk({1'h0, q_al[0]}, {1'h0, rows[i-2][0]});
      @(posedge clk);
      #1;
      chk({q_sp[1], q_al[1]}, {rows[i][1], rows[i][1]});
      if (i > 0) chk({1'h0, q_al[0]}, {1'h0, rows[i-1][0]});
      if (i > 0) chk(q_pl, {rows[i-1][1], rows[i-1][0]});
      @(negedge clk);
    end
    clk_en <= 1'h0;
    pair <= 2'h0;
    repeat (3) @(negedge clk);
    #1.5;
    chk(q_sp, rows[7]);
    chk(q_al, {rows[7][1], rows[6][0]});
    chk(q_pl, rows[6]);
    @(negedge clk);
    lo <= 1'h1;
    #1.5;
    chk(q_al, 2'h0);
    chk(q_sp, rows[7]);
    @(posedge clk);
    #1;
    chk(q_pl, 2'h0);
    chk({1'h0, q_sp[1]}, 2'h0);
    @(negedge clk);
    lo <= 1'h0;
    clk_en <= 1'h1;
    #1.5;
    chk(q_sp, 2'h0);
    chk(q_al, 2'h0);
    // Set raised a cycle after clear has gone, so the two never meet
    @(negedge clk);
    hi <= 1'h1;
    #1.5;
    chk(q_al, 2'h3);
    chk(q_sp, 2'h0);
    @(posedge clk);
    #1;
    chk(q_pl, 2'h3);
    chk(q_sp, 2'h2);
    @(negedge clk);
    hi <= 1'h0;
    #1.5;
    chk(q_sp, 2'h3);
    // Capture resumes; later stages still show the forced level
    @(posedge clk);
    #1;
    chk(q_al, 2'h1);
    chk(q_sp, 2'h1);
    chk(q_pl, 2'h3);
    finish_test();
  end
endmodule
`default_nettype wire
